// ### dv/pkh_kbd_model.sv
`timescale 1ns/10ps
// =====================================================================
// Keyboard model: makes the link clock, takes host frames, answers them
module pkh_kbd_model #(
  parameter logic [7:0] ID_A = 8'hA5, // Arbitrary id value
  parameter logic [7:0] ID_B = 8'h5A  // Arbitrary id value
) (
  input  wire logic       clk_w,
  input  wire logic       data_w,
  input  wire logic       mute,
  input  wire logic       kick,
  input  wire logic [7:0] kick_byte,
  input  wire logic       bad_par,
  output logic            clk_oe,
  output logic            data_oe,
  output logic [7:0]      got
);
  logic [7:0] last_tx;
  logic [9:0] rb;
  initial begin
    clk_oe = 1'b0;
    data_oe = 1'b0;
    got = 8'h00;
    last_tx = 8'h00;
  end
  // One frame out, held off while the host holds the clock low
  task automatic tx(input logic [7:0] v, input logic bad);
    logic [10:0] f;
    f = {1'b1, ~^v ^ bad, v, 1'b0};
    #100;
    wait (clk_w === 1'b1);
    #500;
    last_tx = v;
    for (int i = 0; i < 11; i++) begin
      data_oe = ~f[i];
      #12 clk_oe = 1'b1;
      #24 clk_oe = 1'b0;
      #12;
    end
    data_oe = 1'b0;
  endtask
  // Frames sent on demand of the bench
  always @(posedge kick) tx(kick_byte, bad_par);
  // Host request: data low while the clock is free
  always @(negedge data_w) begin
    #2;
    if (!data_oe && clk_w && !mute) begin
      for (int i = 0; i < 10; i++) begin
        #14 clk_oe = 1'b1;
        #24 clk_oe = 1'b0;
        #10 rb[i] = data_w;
      end
      data_oe = !bad_par;
      #14 clk_oe = 1'b1;
      #24 clk_oe = 1'b0;
      #10 data_oe = 1'b0;
      got = (^rb[8:0] === 1'b1 && rb[9] === 1'b1) ? rb[7:0] : ~rb[7:0];
      case (got)
        8'hEE: tx(8'hEE, 1'b0);
        8'hEF, 8'hF1: ;
        8'hFE: tx(last_tx, 1'b0);
        8'hF2: begin
          tx(8'hFA, 1'b0);
          tx(ID_A, 1'b0);
          tx(ID_B, 1'b0);
        end
        default: tx(8'hFA, 1'b0);
      endcase
    end
  end
endmodule : pkh_kbd_model

// ### dv/pkh_link_tb.sv
`timescale 1ns/10ps
// =====================================================================
// Self-checking bench for the keyboard host link
module pkh_link_tb;
  localparam int INH = 40;
  localparam int TO  = 400;
  typedef struct packed {logic [7:0] tx; logic ans; logic [7:0] rx;} pkh_row_t;
  localparam pkh_row_t ROWS [10] = '{
    '{8'hED, 1'b1, 8'hFA}, '{8'h05, 1'b1, 8'hFA}, '{8'hEE, 1'b1, 8'hEE},
    '{8'hF0, 1'b1, 8'hFA}, '{8'h03, 1'b1, 8'hFA}, '{8'hF3, 1'b1, 8'hFA},
    '{8'h2A, 1'b1, 8'hFA}, '{8'hEF, 1'b0, 8'h00}, '{8'hF1, 1'b0, 8'h00},
    '{8'hF2, 1'b1, 8'hFA}};
  logic        CLK, RESET, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, KBD_IRQ;
  logic        KBD_CLK_OE, KBD_DATA_OE, kb_clk_oe, kb_data_oe, kick, bad_par, mute, d_q, c_q;
  logic [3:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, inh_len, cnt, rd;
  logic [7:0]  kick_byte, got;
  wire         kclk = ~(KBD_CLK_OE | kb_clk_oe);
  wire         kdat = ~(KBD_DATA_OE | kb_data_oe);
  int          mismatches, n_checks, n;

  // =====================================================================
  // Clock, design and keyboard
  initial CLK = 1'b0;
  always #2.5 CLK = ~CLK;
  pkh_link #(.INH_CYC(INH), .TO_CYC(TO)) i_dut (.CLK(CLK), .RESET(RESET),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .KBD_CLK_IN(kclk), .KBD_CLK_OUT(),
    .KBD_CLK_OE(KBD_CLK_OE), .KBD_DATA_IN(kdat), .KBD_DATA_OUT(),
    .KBD_DATA_OE(KBD_DATA_OE), .KBD_IRQ(KBD_IRQ));
  pkh_kbd_model i_kbd (.clk_w(kclk), .data_w(kdat), .mute(mute), .kick(kick),
    .kick_byte(kick_byte), .bad_par(bad_par), .clk_oe(kb_clk_oe),
    .data_oe(kb_data_oe), .got(got));
  // Length of each clock-low hold, and of the one before a request
  always @(posedge CLK) begin
    c_q <= KBD_CLK_OE;
    d_q <= KBD_DATA_OE;
    if (KBD_CLK_OE) cnt <= c_q ? cnt + 32'h1 : 32'h1;
    if (KBD_DATA_OE && !d_q) inh_len <= cnt;
  end

  // =====================================================================
  // Tasks
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int k;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= wd;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (AVS_WAITREQUEST !== 1'b0 && k < 50);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    if (k >= 50) begin
      chk("waitrequest", 32'h0, 32'h1);
      end_sim();
    end
    @(posedge CLK);
  endtask : bus
  task automatic wait_st(input int bit_n, input logic v, input int lim);
    int k;
    k = 0;
    do begin
      bus(1'b0, pkh_pkg::OFS_STATUS, 32'h0);
      k++;
    end while (rd[bit_n] !== v && k < lim);
    if (rd[bit_n] !== v) begin
      chk("status wait", {31'h0, v}, {31'h0, rd[bit_n]});
      end_sim();
    end
  endtask : wait_st
  task automatic rx_chk(input logic [7:0] e);
    wait_st(pkh_pkg::ST_RXFULL, 1'b1, 3000);
    bus(1'b0, pkh_pkg::OFS_DATA, 32'h0);
    chk("rx byte", {24'h0, e}, {24'h0, rd[7:0]});
  endtask : rx_chk
  task automatic send(input logic [7:0] v, input logic ok);
    bus(1'b1, pkh_pkg::OFS_STATUS, 32'h0000_003C);
    bus(1'b1, pkh_pkg::OFS_DATA, {24'h0, v});
    wait_st(pkh_pkg::ST_BUSY, 1'b0, 3000);
    chk("inhibit", 32'h1, {31'h0, inh_len >= INH});
    chk("hold", 32'h1, {31'h0, ok ? cnt >= pkh_pkg::HOLD_CYC : cnt == INH});
  endtask : send
  task automatic kb_send(input logic [7:0] v);
    kick_byte <= v;
    kick <= 1'b1;
    @(posedge CLK);
    kick <= 1'b0;
  endtask : kb_send

  // =====================================================================
  // Main sequence
  initial begin
    {RESET, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} = {3'b100, 36'h0};
    {kick, bad_par, mute, kick_byte} = '0;
    {mismatches, n_checks} = '0;
    repeat (16) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    bus(1'b0, pkh_pkg::OFS_SHADOW, 32'h0);
    chk("shadow reset", 32'h0000_0200, rd);
    bus(1'b0, pkh_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (int r = 0; r < 10; r++) begin
      send(ROWS[r].tx, 1'b1);
      chk("kbd got", {24'h0, ROWS[r].tx}, {24'h0, got});
      chk("line ack", 32'h1, {31'h0, rd[pkh_pkg::ST_ACKOK]});
      if (ROWS[r].ans) rx_chk(ROWS[r].rx);
      else begin
        repeat (3000) @(posedge CLK);
        bus(1'b0, pkh_pkg::OFS_STATUS, 32'h0);
        chk("no answer", 32'h0, {31'h0, rd[pkh_pkg::ST_RXFULL]});
      end
    end
    rx_chk(i_kbd.ID_A);
    rx_chk(i_kbd.ID_B);
    bus(1'b0, pkh_pkg::OFS_SHADOW, 32'h0);
    chk("shadow", 32'h002A_0305, rd);
    // Reset in mid-run brings the shadow back to mode 2
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    bus(1'b0, pkh_pkg::OFS_SHADOW, 32'h0);
    chk("shadow after reset", 32'h0000_0200, rd);
    // Interrupt on a received byte, dropped by reading it
    bus(1'b1, pkh_pkg::OFS_CTRL, 32'h1);
    kb_send(8'h1C);
    n = 0;
    while (KBD_IRQ !== 1'b1 && n < 3000) begin
      @(posedge CLK);
      n++;
    end
    chk("irq up", 32'h1, {31'h0, KBD_IRQ});
    rx_chk(8'h1C);
    repeat (3) @(posedge CLK);
    chk("irq down", 32'h0, {31'h0, KBD_IRQ});
    // Send queued while a keyboard frame is in flight
    kb_send(8'h2B);
    repeat (150) @(posedge CLK);
    bus(1'b1, pkh_pkg::OFS_DATA, 32'h0000_00EE);
    rx_chk(8'h2B);
    rx_chk(8'hEE);
    // Bad parity from the keyboard draws a resend request
    bus(1'b1, pkh_pkg::OFS_CTRL, 32'h3);
    bad_par <= 1'b1;
    kb_send(8'h33);
    bad_par <= 1'b0;
    n = 0;
    while (got !== 8'hFE && n < 20000) begin
      @(posedge CLK);
      n++;
    end
    chk("resend code", 32'hFE, {24'h0, got});
    rx_chk(8'h33);
    bus(1'b0, pkh_pkg::OFS_STATUS, 32'h0);
    chk("parity flag", 32'h1, {31'h0, rd[pkh_pkg::ST_PARERR]});
    // Keyboard that leaves the line ack out raises the missing-ack flag
    bad_par <= 1'b1;
    send(8'hF4, 1'b1);
    bad_par <= 1'b0;
    chk("nak flag", 32'h1, {31'h0, rd[pkh_pkg::ST_NAK]});
    chk("no line ack", 32'h0, {31'h0, rd[pkh_pkg::ST_ACKOK]});
    rx_chk(8'hFA);
    // Silent keyboard ends in a timeout
    mute <= 1'b1;
    send(8'hF4, 1'b0);
    chk("timeout", 32'h1, {31'h0, rd[pkh_pkg::ST_TIMEOUT]});
    mute <= 1'b0;
    end_sim();
  end
endmodule : pkh_link_tb

// ### hw/pkh_line_sync.sv
`timescale 1ns/10ps
// =====================================================================
// Two-flop synchronisers for the link pins and clock fall detection
module pkh_line_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic clk_pin,
  input  wire logic data_pin,
  output logic      clk_level,
  output logic      data_level,
  output logic      clk_fall
);

  logic [1:0] meta_reg;
  logic [1:0] sync_reg;
  logic       clk_last_reg;

  // Synchronise both lines; idle lines float high
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg     <= 2'h3;
      sync_reg     <= 2'h3;
      clk_last_reg <= 1'b1;
    end else begin
      meta_reg     <= {data_pin, clk_pin};
      sync_reg     <= meta_reg;
      clk_last_reg <= sync_reg[0];
    end
  end

  assign clk_level  = sync_reg[0];
  assign data_level = sync_reg[1];
  assign clk_fall   = clk_last_reg & ~sync_reg[0];

endmodule : pkh_line_sync

// ### hw/pkh_link.sv
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
// =====================================================================
// Keyboard host link controller with Avalon-MM register slave
module pkh_link #(
  parameter int unsigned INH_CYC = pkh_pkg::INHIBIT_CYC,
  parameter int unsigned TO_CYC  = pkh_pkg::TIMEOUT_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        KBD_CLK_IN,
  output logic             KBD_CLK_OUT,
  output logic             KBD_CLK_OE,
  input  wire logic        KBD_DATA_IN,
  output logic             KBD_DATA_OUT,
  output logic             KBD_DATA_OE,
  output logic             KBD_IRQ
);

  localparam logic [pkh_pkg::TMR_W-1:0] INH_LAST  = pkh_pkg::TMR_W'(INH_CYC - 1);
  localparam logic [pkh_pkg::TMR_W-1:0] TO_LAST   = pkh_pkg::TMR_W'(TO_CYC - 1);
  localparam logic [pkh_pkg::TMR_W-1:0] HOLD_LAST = pkh_pkg::TMR_W'(pkh_pkg::HOLD_CYC - 1);

  pkh_pkg::pkh_state_t         state_reg;
  pkh_pkg::pkh_state_t         state_next;
  logic [pkh_pkg::TMR_W-1:0]   timer_reg;
  logic [3:0]                  idx_reg;
  logic                        line_clk;
  logic                        line_data;
  logic                        fall;
  logic                        waiting;
  logic                        timeout;
  logic [7:0]                  tx_hold_reg;
  logic [7:0]                  tx_shift_reg;
  logic                        tx_pend_reg;
  logic                        tx_bit;
  logic [8:0]                  rx_shift_reg;
  logic [7:0]                  rx_data_reg;
  logic                        rx_full_reg;
  logic                        rx_end;
  logic                        rx_ok;
  logic                        rx_bad;
  logic                        tx_end;
  logic [5:2]                  err_reg;
  logic [1:0]                  ctrl_reg;
  logic [2:0]                  led_reg;
  logic [1:0]                  mode_reg;
  logic [6:0]                  type_reg;
  logic [7:0]                  prev_cmd_reg;
  logic                        ack_reg;
  logic                        bus_wr;
  logic                        bus_rd;
  logic                        resend;
  logic                        irq_reg;
  logic [31:0]                 rdata_reg;
  logic [31:0]                 status_word;

  // ===================================================================
  // Pin synchronisation
  pkh_line_sync u_sync (
    .clk        (CLK),
    .reset      (RESET),
    .clk_pin    (KBD_CLK_IN),
    .data_pin   (KBD_DATA_IN),
    .clk_level  (line_clk),
    .data_level (line_data),
    .clk_fall   (fall)
  );

  // ===================================================================
  // Avalon-MM slave: one wait cycle, then the access completes
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (AVS_READ | AVS_WRITE) & ~ack_reg;
    end
  end

  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
  assign bus_wr          = AVS_WRITE & ack_reg;
  assign bus_rd          = AVS_READ & ack_reg;

  // Status word assembly
  always_comb begin
    status_word                      = 32'h0000_0000;
    status_word[pkh_pkg::ST_RXFULL]  = rx_full_reg;
    status_word[pkh_pkg::ST_BUSY]    = tx_pend_reg | ~(state_reg inside
                                       {pkh_pkg::S_IDLE, pkh_pkg::S_RX});
    status_word[5:2]                 = err_reg;
  end

  // Read data captured in the wait cycle, unmapped reads give zero
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rdata_reg <= 32'h0000_0000;
    end else if (AVS_READ && !ack_reg) begin
      unique case (AVS_ADDRESS)
        pkh_pkg::OFS_DATA:   rdata_reg <= {24'h000000, rx_data_reg};
        pkh_pkg::OFS_STATUS: rdata_reg <= status_word;
        pkh_pkg::OFS_CTRL:   rdata_reg <= {30'h0, ctrl_reg};
        pkh_pkg::OFS_SHADOW: rdata_reg <= {9'h0, type_reg, 6'h0, mode_reg, 5'h0, led_reg};
        default:             rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign AVS_READDATA = rdata_reg;

  // Control register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_reg <= pkh_pkg::CTRL_RST;
    end else if (bus_wr && AVS_ADDRESS == pkh_pkg::OFS_CTRL) begin
      ctrl_reg <= AVS_WRITEDATA[1:0];
    end
  end

  // ===================================================================
  // Link state machine
  assign waiting = state_reg inside {pkh_pkg::S_RX, pkh_pkg::S_REQ, pkh_pkg::S_TX,
                                     pkh_pkg::S_ACK};
  assign timeout = waiting && timer_reg == TO_LAST;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pkh_pkg::S_IDLE: begin
        if (tx_pend_reg) begin
          state_next = pkh_pkg::S_INHIBIT;
        end else if (fall && !line_data) begin
          state_next = pkh_pkg::S_RX;
        end
      end
      pkh_pkg::S_RX: begin
        // A pending send waits here until the frame ends
        if (timeout || (fall && idx_reg == pkh_pkg::IDX_STOP)) begin
          state_next = pkh_pkg::S_IDLE;
        end
      end
      pkh_pkg::S_INHIBIT: begin
        if (timer_reg >= INH_LAST) begin
          state_next = pkh_pkg::S_REQ;
        end
      end
      pkh_pkg::S_REQ: begin
        if (timeout) begin
          state_next = pkh_pkg::S_IDLE;
        end else if (fall) begin
          state_next = pkh_pkg::S_TX;
        end
      end
      pkh_pkg::S_TX: begin
        if (timeout) begin
          state_next = pkh_pkg::S_IDLE;
        end else if (fall && idx_reg == pkh_pkg::IDX_PARITY) begin
          state_next = pkh_pkg::S_ACK;
        end
      end
      pkh_pkg::S_ACK: begin
        if (timeout) begin
          state_next = pkh_pkg::S_IDLE;
        end else if (fall) begin
          state_next = pkh_pkg::S_HOLD;
        end
      end
      pkh_pkg::S_HOLD: begin
        if (timer_reg >= HOLD_LAST) begin
          state_next = pkh_pkg::S_IDLE;
        end
      end
      default: state_next = pkh_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_reg <= pkh_pkg::S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Timer restarts on each state change and each link clock fall in a waiting state
  always_ff @(posedge CLK) begin
    if (RESET || state_next != state_reg || (waiting && fall)) begin
      timer_reg <= '0;
    end else if (state_reg != pkh_pkg::S_IDLE) begin
      timer_reg <= timer_reg + 1'b1;
    end
  end

  // Frame bit index, advanced by keyboard clock falls
  always_ff @(posedge CLK) begin
    if (RESET || state_reg inside {pkh_pkg::S_IDLE, pkh_pkg::S_REQ}) begin
      idx_reg <= 4'h0;
    end else if (fall && state_reg inside {pkh_pkg::S_RX, pkh_pkg::S_TX}) begin
      idx_reg <= idx_reg + 4'h1;
    end
  end

  // ===================================================================
  // Transmit path
  always_comb begin
    if (idx_reg < pkh_pkg::IDX_PARITY) begin
      tx_bit = tx_shift_reg[idx_reg[2:0]];
    end else if (idx_reg == pkh_pkg::IDX_PARITY) begin
      tx_bit = ~^tx_shift_reg;
    end else begin
      tx_bit = 1'b1;
    end
  end

  assign resend = rx_bad && ctrl_reg[pkh_pkg::CT_AUTORESEND];

  // Pending byte: software write or automatic resend; the set wins
  always_ff @(posedge CLK) begin
    if (RESET) begin
      tx_hold_reg <= 8'h00;
      tx_pend_reg <= 1'b0;
    end else if (resend) begin
      tx_hold_reg <= pkh_pkg::CMD_RESEND;
      tx_pend_reg <= 1'b1;
    end else if (bus_wr && AVS_ADDRESS == pkh_pkg::OFS_DATA) begin
      tx_hold_reg <= AVS_WRITEDATA[7:0];
      tx_pend_reg <= 1'b1;
    end else if (state_reg == pkh_pkg::S_IDLE) begin
      tx_pend_reg <= 1'b0;
    end
  end

  // Byte frozen for the frame when the inhibit starts
  always_ff @(posedge CLK) begin
    if (RESET) begin
      tx_shift_reg <= 8'h00;
    end else if (state_reg == pkh_pkg::S_IDLE && tx_pend_reg) begin
      tx_shift_reg <= tx_hold_reg;
    end
  end

  assign tx_end = state_reg == pkh_pkg::S_ACK && fall;

  // Shadow of option bytes the keyboard accepted
  always_ff @(posedge CLK) begin
    if (RESET) begin
      prev_cmd_reg <= 8'h00;
      led_reg      <= pkh_pkg::LED_RST;
      mode_reg     <= pkh_pkg::MODE_RST;
      type_reg     <= pkh_pkg::TYPE_RST;
    end else if (tx_end && !line_data) begin
      prev_cmd_reg <= tx_shift_reg;
      if (prev_cmd_reg == pkh_pkg::CMD_LEDS) begin
        led_reg <= tx_shift_reg[2:0];
      end
      if (prev_cmd_reg == pkh_pkg::CMD_SCANSET && tx_shift_reg >= pkh_pkg::SCAN_MODE1
          && tx_shift_reg <= pkh_pkg::SCAN_MODE3) begin
        mode_reg <= tx_shift_reg[1:0];
      end
      if (prev_cmd_reg == pkh_pkg::CMD_TYPEMATIC) begin
        type_reg <= tx_shift_reg[6:0];
      end
    end
  end

  // ===================================================================
  // Receive path
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rx_shift_reg <= 9'h000;
    end else if (fall && state_reg == pkh_pkg::S_RX && idx_reg < pkh_pkg::IDX_STOP) begin
      rx_shift_reg <= {line_data, rx_shift_reg[8:1]};
    end
  end

  assign rx_end = state_reg == pkh_pkg::S_RX && fall && idx_reg == pkh_pkg::IDX_STOP;
  assign rx_ok  = rx_end && (^rx_shift_reg) && line_data;
  assign rx_bad = (rx_end && !rx_ok) || (state_reg == pkh_pkg::S_RX && timeout);

  // Received byte; a read clears full unless a new byte lands
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rx_data_reg <= 8'h00;
      rx_full_reg <= 1'b0;
    end else if (rx_ok) begin
      rx_data_reg <= rx_shift_reg[7:0];
      rx_full_reg <= 1'b1;
    end else if (bus_rd && AVS_ADDRESS == pkh_pkg::OFS_DATA) begin
      rx_full_reg <= 1'b0;
    end
  end

  // Sticky error and result flags, write one to clear, set wins
  always_ff @(posedge CLK) begin
    if (RESET) begin
      err_reg <= 4'h0;
    end else begin
      err_reg <= (bus_wr && AVS_ADDRESS == pkh_pkg::OFS_STATUS)
                 ? err_reg & ~AVS_WRITEDATA[5:2] : err_reg;
      if (rx_end && !rx_ok) err_reg[pkh_pkg::ST_PARERR] <= 1'b1;
      if (timeout) err_reg[pkh_pkg::ST_TIMEOUT] <= 1'b1;
      if (tx_end && !line_data) err_reg[pkh_pkg::ST_ACKOK] <= 1'b1;
      if (tx_end && line_data) err_reg[pkh_pkg::ST_NAK] <= 1'b1;
    end
  end

  // Interrupt on a held received byte
  always_ff @(posedge CLK) begin
    if (RESET) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= rx_full_reg & ctrl_reg[pkh_pkg::CT_IRQEN];
    end
  end

  assign KBD_IRQ = irq_reg;

  // ===================================================================
  // Open-drain pin drive: host only ever pulls low
  assign KBD_CLK_OUT  = 1'b0;
  assign KBD_CLK_OE   = state_reg inside {pkh_pkg::S_INHIBIT, pkh_pkg::S_HOLD};
  assign KBD_DATA_OUT = 1'b0;
  assign KBD_DATA_OE  = state_reg == pkh_pkg::S_REQ ||
                        (state_reg == pkh_pkg::S_TX && !tx_bit);

  // ===================================================================
  // Assertions
  a_inhibit_long: assert property (@(posedge CLK) disable iff (RESET)
    (state_reg == pkh_pkg::S_INHIBIT && state_next == pkh_pkg::S_REQ)
      |-> (timer_reg >= INH_LAST && KBD_CLK_OE))
    else $error("clock inhibit released too early");

  a_rx_no_inhibit: assert property (@(posedge CLK) disable iff (RESET)
    (state_reg == pkh_pkg::S_RX) |=> (state_reg != pkh_pkg::S_INHIBIT))
    else $error("inhibit entered during receive");

  a_start_low: assert property (@(posedge CLK) disable iff (RESET)
    (state_reg == pkh_pkg::S_REQ) |-> (KBD_DATA_OE && !KBD_CLK_OE))
    else $error("start request not driven");

  a_lsb_first: assert property (@(posedge CLK) disable iff (RESET)
    $rose(state_reg == pkh_pkg::S_TX) |-> (KBD_DATA_OE == !tx_shift_reg[0]))
    else $error("first data bit not the lsb");

  a_odd_parity: assert property (@(posedge CLK) disable iff (RESET)
    (state_reg == pkh_pkg::S_TX && idx_reg == pkh_pkg::IDX_PARITY)
      |-> (KBD_DATA_OE == (^tx_shift_reg)))
    else $error("parity bit not odd");

  a_hold_after: assert property (@(posedge CLK) disable iff (RESET)
    (state_reg == pkh_pkg::S_ACK && fall) |=> (state_reg == pkh_pkg::S_HOLD) ##1 KBD_CLK_OE)
    else $error("clock not held after stop");

  a_never_drive_high: assert property (@(posedge CLK) disable iff (RESET)
    !KBD_CLK_OUT && !KBD_DATA_OUT)
    else $error("host drove a line high");

  a_resend_queued: assert property (@(posedge CLK) disable iff (RESET)
    resend |=> (tx_pend_reg && tx_hold_reg == pkh_pkg::CMD_RESEND))
    else $error("resend not queued");

  a_irq_follow: assert property (@(posedge CLK) disable iff (RESET)
    (rx_ok && ctrl_reg[pkh_pkg::CT_IRQEN]) |=> ##1 KBD_IRQ)
    else $error("interrupt missing");

  a_timeout_abort: assert property (@(posedge CLK) disable iff (RESET)
    timeout |=> (state_reg == pkh_pkg::S_IDLE && err_reg[pkh_pkg::ST_TIMEOUT]))
    else $error("timeout did not abort");

endmodule : pkh_link

// ### hw/pkh_pkg.sv
// =====================================================================
// Shared constants for the keyboard host link
package pkh_pkg;

  // ===================================================================
  // Timing
  localparam int CLK_MHZ      = 200;                    // System clock rate
  localparam int INHIBIT_US   = 60;                     // Least clock hold before send
  localparam int INHIBIT_CYC  = INHIBIT_US * CLK_MHZ;   // Rounded up: exact
  localparam int TIMEOUT_US   = 2000;                   // Longest wait for a link edge
  localparam int TIMEOUT_CYC  = TIMEOUT_US * CLK_MHZ;   // Rounded down: exact
  localparam int HOLD_US      = 10;                     // Clock hold after a sent byte
  localparam int HOLD_CYC     = HOLD_US * CLK_MHZ;
  localparam int TMR_W        = 19;                     // Timer width

  // ===================================================================
  // Register byte offsets
  localparam logic [3:0] OFS_DATA   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_CTRL   = 4'h8;
  localparam logic [3:0] OFS_SHADOW = 4'hC;

  // Status bit positions
  localparam int ST_RXFULL  = 0;
  localparam int ST_BUSY    = 1;
  localparam int ST_PARERR  = 2;
  localparam int ST_TIMEOUT = 3;
  localparam int ST_ACKOK   = 4;
  localparam int ST_NAK     = 5;

  // Control bit positions and reset value
  localparam int         CT_IRQEN      = 0;
  localparam int         CT_AUTORESEND = 1;
  localparam logic [1:0] CTRL_RST      = 2'h0;

  // Shadow register field positions and reset values
  localparam int         SH_LED_LSB  = 0;
  localparam int         SH_MODE_LSB = 8;
  localparam int         SH_TYPE_LSB = 16;
  localparam logic [1:0] MODE_RST    = 2'h2;
  localparam logic [2:0] LED_RST     = 3'h0;
  localparam logic [6:0] TYPE_RST    = 7'h00;

  // ===================================================================
  // Keyboard command codes
  localparam logic [7:0] CMD_LEDS      = 8'hED;
  localparam logic [7:0] CMD_ECHO      = 8'hEE;
  localparam logic [7:0] CMD_BAD_A     = 8'hEF;
  localparam logic [7:0] CMD_SCANSET   = 8'hF0;
  localparam logic [7:0] CMD_BAD_B     = 8'hF1;
  localparam logic [7:0] CMD_READID    = 8'hF2;
  localparam logic [7:0] CMD_TYPEMATIC = 8'hF3;
  localparam logic [7:0] CMD_RESEND    = 8'hFE;
  localparam logic [7:0] SCAN_MODE1    = 8'h01;
  localparam logic [7:0] SCAN_MODE3    = 8'h03;

  // Frame bit indices
  localparam logic [3:0] IDX_PARITY = 4'h8;
  localparam logic [3:0] IDX_STOP   = 4'h9;

  // ===================================================================
  // Link state machine
  typedef enum logic [6:0] {
    S_IDLE    = 7'h01,
    S_RX      = 7'h02,
    S_INHIBIT = 7'h04,
    S_REQ     = 7'h08,
    S_TX      = 7'h10,
    S_ACK     = 7'h20,
    S_HOLD    = 7'h40
  } pkh_state_t;

endpackage : pkh_pkg
